// >>> mas_consts.vh
// Constants shared by the multiply-accumulate slice and its self-checking bench.
`ifndef MAS_CONSTS_VH
`define MAS_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets on the APB register bus
// ----------------------------------------------------------------------
`define MAS_REG_CFG 8'h00
`define MAS_REG_SEL 8'h04
`define MAS_REG_STAT 8'h08
`define MAS_REG_RESLO 8'h0c
`define MAS_REG_RESHI 8'h10

// ----------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------
`define MAS_CFG_MODE_LO 0
`define MAS_CFG_MODE_HI 1
`define MAS_CFG_IN_EN 2
`define MAS_CFG_PIPE_EN 3
`define MAS_CFG_OUT_EN 4
`define MAS_CFG_SIGNED 5
`define MAS_CFG_SUB 6
`define MAS_CFG_DYN 7
`define MAS_CFG_RESET 8'h1c

// ----------------------------------------------------------------------
// Element modes
// ----------------------------------------------------------------------
`define MAS_MODE_MUL 2'h0
`define MAS_MODE_MAC 2'h1
`define MAS_MODE_TWO 2'h2
`define MAS_MODE_FOUR 2'h3

// ----------------------------------------------------------------------
// Stage select register: six bits per stage, at byte positions
// ----------------------------------------------------------------------
`define MAS_SEL_IN_LO 0
`define MAS_SEL_PIPE_LO 8
`define MAS_SEL_OUT_LO 16
`define MAS_SEL_RESET 24'h000000

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define MAS_STAT_CNT_W 16

`endif

// >>> mas_stage.v
// Bypassable register stage with selectable clock, enable and reset source.
`timescale 1ns/100ps
module mas_stage #(
	parameter WD = 8
) (
	ref_clk,
	sys_rst,
	clkTick,
	ceSrc,
	rstSrc,
	stageSel,
	present,
	d,
	q,
	fire
);
	input wire ref_clk;
	input wire sys_rst;
	input wire [3:0] clkTick;
	input wire [3:0] ceSrc;
	input wire [3:0] rstSrc;
	input wire [5:0] stageSel;
	input wire present;
	input wire [WD-1:0] d;
	output wire [WD-1:0] q;
	output wire fire;

	reg [WD-1:0] q_r;
	wire clrNow;

	// ------------------------------------------------------------------
	// Source selection and the stage register
	// ------------------------------------------------------------------
	assign fire = clkTick[stageSel[1:0]] & ceSrc[stageSel[3:2]];
	assign clrNow = rstSrc[stageSel[5:4]];

	always @(posedge ref_clk) begin
		if (sys_rst || clrNow) begin
			q_r <= {WD{1'b0}};
		end else if (fire) begin
			q_r <= d;
		end
	end

	assign q = present ? q_r : d;
endmodule // mas_stage

// >>> mas_slice.v
// Configurable multiply, multiply-accumulate and sum-of-products slice.
//
// Overview of operation
// - Accumulate variant adds product to held value.
// - Accumulate variant always keeps its output register.
// - Accumulate input and pipeline stages are bypassable.
// - Accumulator loads an initial value at run time.
// - Overflow output comes from a register.
// - Two-product variant outputs A0B0 plus/minus A1B1.
// - Four-product variant also forms A2B2 plus/minus A3B3.
// - Four-product variant sums both pair results.
// - Sum variants bypass any stage by configuration.
// - Each stage picks one of four clocks.
// - Each stage picks enable and reset sources.
// - Accumulator wraps on overflow and flags it.
// - Unsigned overflow when sum below previous value, or above it when subtracting.
// - Signed overflow when operand signs break sum.
// - Overflow pulse lasts one cycle per overflowing accumulate.
// - Dynamic mode picks signedness every cycle.
// - Dynamic mode picks add or subtract every cycle.
// - One signedness and width for the whole slice.
`timescale 1ns/100ps
`include "mas_consts.vh"
module mas_slice #(
	parameter W = 18,
	parameter ACCW = 52
) (
	ref_clk,
	sys_rst,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	slice_clock_source_0,
	slice_clock_source_1,
	slice_clock_source_2,
	slice_clock_source_3,
	slice_enable_source_0,
	slice_enable_source_1,
	slice_enable_source_2,
	slice_enable_source_3,
	slice_reset_source_0,
	slice_reset_source_1,
	slice_reset_source_2,
	slice_reset_source_3,
	opA0,
	opB0,
	opA1,
	opB1,
	opA2,
	opB2,
	opA3,
	opB3,
	signedIn,
	subIn,
	accLoad,
	accInit,
	result,
	overflow
);
	input wire ref_clk;
	input wire sys_rst;
	input wire psel;
	input wire penable;
	input wire pwrite;
	input wire [7:0] paddr;
	input wire [31:0] pwdata;
	output reg [31:0] prdata;
	output reg pready;
	output reg pslverr;
	input wire slice_clock_source_0;
	input wire slice_clock_source_1;
	input wire slice_clock_source_2;
	input wire slice_clock_source_3;
	input wire slice_enable_source_0;
	input wire slice_enable_source_1;
	input wire slice_enable_source_2;
	input wire slice_enable_source_3;
	input wire slice_reset_source_0;
	input wire slice_reset_source_1;
	input wire slice_reset_source_2;
	input wire slice_reset_source_3;
	input wire [W-1:0] opA0;
	input wire [W-1:0] opB0;
	input wire [W-1:0] opA1;
	input wire [W-1:0] opB1;
	input wire [W-1:0] opA2;
	input wire [W-1:0] opB2;
	input wire [W-1:0] opA3;
	input wire [W-1:0] opB3;
	input wire signedIn;
	input wire subIn;
	input wire accLoad;
	input wire [ACCW-1:0] accInit;
	output reg [ACCW-1:0] result;
	output reg overflow;

	localparam PW = 2 * W;
	localparam INW = 8 * W + 3 + ACCW;
	localparam PPW = 4 * PW + 3 + ACCW;

	// ------------------------------------------------------------------
	// Arithmetic helpers
	// ------------------------------------------------------------------
	function [PW-1:0] mulOp;
		input [W-1:0] a;
		input [W-1:0] b;
		input sgn;
		reg [PW-1:0] ea;
		reg [PW-1:0] eb;
		begin
			ea = sgn ? {{W{a[W-1]}}, a} : {{W{1'b0}}, a};
			eb = sgn ? {{W{b[W-1]}}, b} : {{W{1'b0}}, b};
			mulOp = ea * eb;
		end
	endfunction

	function [ACCW-1:0] extP;
		input [PW-1:0] p;
		input sgn;
		begin
			if (sgn) begin
				extP = {{(ACCW-PW){p[PW-1]}}, p};
			end else begin
				extP = {{(ACCW-PW){1'b0}}, p};
			end
		end
	endfunction

	function [ACCW-1:0] addSub;
		input [ACCW-1:0] x;
		input [ACCW-1:0] y;
		input sub;
		begin
			addSub = sub ? x - y : x + y;
		end
	endfunction

	// ------------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------------
	reg [7:0] cfg_r;
	reg [23:0] sel_r;
	reg [`MAS_STAT_CNT_W-1:0] ovfCnt_r;
	reg ovfHit_r;

	wire [1:0] mode;
	wire isMac;
	wire apbAccess;
	wire apbWrite;
	wire [63:0] resWide;

	assign mode = cfg_r[`MAS_CFG_MODE_HI:`MAS_CFG_MODE_LO];
	assign isMac = (mode == `MAS_MODE_MAC);
	assign apbAccess = psel & penable & pready;
	assign apbWrite = apbAccess & pwrite;
	assign resWide = {{(64-ACCW){1'b0}}, result};

	// ------------------------------------------------------------------
	// APB slave: one wait state, then pready for one cycle
	// ------------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			case (paddr)
				`MAS_REG_CFG: begin
					prdata <= {24'h000000, cfg_r};
				end
				`MAS_REG_SEL: begin
					prdata <= {8'h00, sel_r};
				end
				`MAS_REG_STAT: begin
					prdata <= {16'h0000, ovfCnt_r};
				end
				`MAS_REG_RESLO: begin
					prdata <= resWide[31:0];
				end
				`MAS_REG_RESHI: begin
					prdata <= resWide[63:32];
				end
				default: begin
					pslverr <= 1'b1;
				end
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			cfg_r <= `MAS_CFG_RESET;
			sel_r <= `MAS_SEL_RESET;
		end else if (apbWrite) begin
			if (paddr == `MAS_REG_CFG) begin
				cfg_r <= pwdata[7:0];
			end
			if (paddr == `MAS_REG_SEL) begin
				sel_r <= pwdata[23:0] & 24'h3f3f3f;
			end
		end
	end

	// Overflow counter: a new pulse in the cycle of a software clear restarts the count at one.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			ovfCnt_r <= {`MAS_STAT_CNT_W{1'b0}};
		end else if (ovfHit_r) begin
			if (apbWrite && paddr == `MAS_REG_STAT) begin
				ovfCnt_r <= {{(`MAS_STAT_CNT_W-1){1'b0}}, 1'b1};
			end else begin
				ovfCnt_r <= ovfCnt_r + 1'b1;
			end
		end else if (apbWrite && paddr == `MAS_REG_STAT) begin
			ovfCnt_r <= {`MAS_STAT_CNT_W{1'b0}};
		end
	end

	// ------------------------------------------------------------------
	// Shared clock, enable and reset sources
	// ------------------------------------------------------------------
	wire [3:0] clkTick;
	wire [3:0] ceSrc;
	wire [3:0] rstSrc;

	assign clkTick = {slice_clock_source_3, slice_clock_source_2,
		slice_clock_source_1, slice_clock_source_0};
	assign ceSrc = {slice_enable_source_3, slice_enable_source_2,
		slice_enable_source_1, slice_enable_source_0};
	assign rstSrc = {slice_reset_source_3, slice_reset_source_2,
		slice_reset_source_1, slice_reset_source_0};

	// ------------------------------------------------------------------
	// Input stage
	// ------------------------------------------------------------------
	wire sgnNow;
	wire subNow;
	wire [INW-1:0] inD;
	wire [INW-1:0] inQ;

	assign sgnNow = cfg_r[`MAS_CFG_DYN] ? signedIn
		: cfg_r[`MAS_CFG_SIGNED];
	assign subNow = cfg_r[`MAS_CFG_DYN] ? subIn
		: cfg_r[`MAS_CFG_SUB];
	assign inD = {accLoad, subNow, sgnNow, accInit, opB3, opA3, opB2, opA2,
		opB1, opA1, opB0, opA0};

	mas_stage #(.WD(INW)) inStage (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clkTick(clkTick),
		.ceSrc(ceSrc),
		.rstSrc(rstSrc),
		.stageSel(sel_r[`MAS_SEL_IN_LO+5:`MAS_SEL_IN_LO]),
		.present(cfg_r[`MAS_CFG_IN_EN]),
		.d(inD),
		.q(inQ),
		.fire()
	);

	// ------------------------------------------------------------------
	// Multipliers and pipeline stage
	// ------------------------------------------------------------------
	wire inSgn;
	wire [PPW-1:0] ppD;
	wire [PPW-1:0] ppQ;

	assign inSgn = inQ[8*W+ACCW];
	assign ppD = {inQ[INW-1:8*W],
		mulOp(inQ[7*W-1:6*W], inQ[8*W-1:7*W], inSgn),
		mulOp(inQ[5*W-1:4*W], inQ[6*W-1:5*W], inSgn),
		mulOp(inQ[3*W-1:2*W], inQ[4*W-1:3*W], inSgn),
		mulOp(inQ[W-1:0], inQ[2*W-1:W], inSgn)};

	mas_stage #(.WD(PPW)) pipeStage (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clkTick(clkTick),
		.ceSrc(ceSrc),
		.rstSrc(rstSrc),
		.stageSel(sel_r[`MAS_SEL_PIPE_LO+5:`MAS_SEL_PIPE_LO]),
		.present(cfg_r[`MAS_CFG_PIPE_EN]),
		.d(ppD),
		.q(ppQ),
		.fire()
	);

	// ------------------------------------------------------------------
	// Sums of products and the accumulator
	// ------------------------------------------------------------------
	wire pLoad;
	wire pSub;
	wire pSgn;
	wire [ACCW-1:0] pInit;
	wire [ACCW-1:0] e0;
	wire [ACCW-1:0] e1;
	wire [ACCW-1:0] e2;
	wire [ACCW-1:0] e3;
	wire [ACCW-1:0] pair01;
	wire [ACCW-1:0] pair23;
	wire [ACCW-1:0] acc;
	wire [ACCW-1:0] accSum;
	wire addSign;
	wire ovfNow;
	reg [ACCW-1:0] outD;
	wire [ACCW-1:0] outQ;
	wire outFire;

	assign pLoad = ppQ[PPW-1];
	assign pSub = ppQ[PPW-2];
	assign pSgn = ppQ[PPW-3];
	assign pInit = ppQ[4*PW+ACCW-1:4*PW];
	assign e0 = extP(ppQ[PW-1:0], pSgn);
	assign e1 = extP(ppQ[2*PW-1:PW], pSgn);
	assign e2 = extP(ppQ[3*PW-1:2*PW], pSgn);
	assign e3 = extP(ppQ[4*PW-1:3*PW], pSgn);
	assign pair01 = addSub(e0, e1, pSub);
	assign pair23 = addSub(e2, e3, pSub);

	// Accumulator wraps; overflow is judged against the held value.
	assign acc = outQ;
	assign accSum = addSub(acc, e0, pSub);
	assign addSign = pSub ? ~e0[ACCW-1] : e0[ACCW-1];
	assign ovfNow = pSgn
		? ((acc[ACCW-1] == addSign) && (accSum[ACCW-1] != acc[ACCW-1]))
		: (pSub ? (accSum > acc) : (accSum < acc));

	always @* begin
		case (mode)
			`MAS_MODE_MUL: begin
				outD = e0;
			end
			`MAS_MODE_MAC: begin
				outD = pLoad ? pInit : accSum;
			end
			`MAS_MODE_TWO: begin
				outD = pair01;
			end
			`MAS_MODE_FOUR: begin
				outD = pair01 + pair23;
			end
			default: begin
				outD = e0;
			end
		endcase
	end

	mas_stage #(.WD(ACCW)) outStage (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clkTick(clkTick),
		.ceSrc(ceSrc),
		.rstSrc(rstSrc),
		.stageSel(sel_r[`MAS_SEL_OUT_LO+5:`MAS_SEL_OUT_LO]),
		.present(cfg_r[`MAS_CFG_OUT_EN] | isMac),
		.d(outD),
		.q(outQ),
		.fire(outFire)
	);

	// ------------------------------------------------------------------
	// Result and overflow outputs
	// ------------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			ovfHit_r <= 1'b0;
			overflow <= 1'b0;
			result <= {ACCW{1'b0}};
		end else begin
			ovfHit_r <= isMac & outFire & ~pLoad & ovfNow;
			overflow <= ovfHit_r;
			result <= outQ;
		end
	end
endmodule // mas_slice

// >>> mas_slice_chk.sv
// Port checker for the multiply-accumulate slice.
`timescale 1ns/100ps
module mas_slice_chk #(
	parameter W = 18,
	parameter ACCW = 52
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire slice_clock_source_0,
	input wire slice_clock_source_1,
	input wire slice_clock_source_2,
	input wire slice_clock_source_3,
	input wire slice_reset_source_0,
	input wire slice_reset_source_1,
	input wire slice_reset_source_2,
	input wire slice_reset_source_3,
	input wire [ACCW-1:0] result,
	input wire overflow
);
	// --------
	// Checks
	// --------
	wire anyAct;
	assign anyAct = slice_clock_source_0 | slice_clock_source_1 |
		slice_clock_source_2 | slice_clock_source_3 | slice_reset_source_0 |
		slice_reset_source_1 | slice_reset_source_2 | slice_reset_source_3 |
		sys_rst;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	reset_clear_a: assert property (disable iff (1'b0)
		sys_rst |=> result == '0 && !overflow && !pready)
		else $error("outputs not cleared by reset");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	ready_cause_a: assert property (pready |-> psel && penable &&
		$past(psel && penable)) else $error("pready outside access");
	wait_state_a: assert property (psel && penable && !$past(penable)
		|=> pready) else $error("access not one wait state");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	ovf_single_a: assert property (
		overflow |=> !overflow || result != $past(result))
		else $error("overflow longer than one event");
	ovf_with_sum_a: assert property (
		overflow |-> result != $past(result))
		else $error("overflow without new sum");
	stage_gate_a: assert property (
		result != $past(result) |-> $past(anyAct) || $past(anyAct, 2) ||
		$past(anyAct, 3)) else $error("result moved without tick");
	cover property (overflow);
	cover property (pslverr);
	cover property (result != $past(result));
endmodule // mas_slice_chk

bind mas_slice mas_slice_chk #(.W(W), .ACCW(ACCW)) chk (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .slice_clock_source_0(slice_clock_source_0),
	.slice_clock_source_1(slice_clock_source_1),
	.slice_clock_source_2(slice_clock_source_2),
	.slice_clock_source_3(slice_clock_source_3),
	.slice_reset_source_0(slice_reset_source_0),
	.slice_reset_source_1(slice_reset_source_1),
	.slice_reset_source_2(slice_reset_source_2),
	.slice_reset_source_3(slice_reset_source_3),
	.result(result), .overflow(overflow));

// >>> mas_fabric.sv
// Fabric model that widens narrow operands before they reach the slice.
`timescale 1ns/100ps
module mas_fabric #(
	parameter W = 18
) (
	input wire [8*W-1:0] raw,
	input wire [4:0] nbits,
	input wire sgn,
	output reg [8*W-1:0] ops
);
	// --------
	// Widening
	// --------
	integer i;
	integer j;
	always @* begin
		for (i = 0; i < 8; i = i + 1) begin
			for (j = 0; j < W; j = j + 1) begin
				if (j < nbits) begin
					ops[i*W+j] = raw[i*W+j];
				end else begin
					ops[i*W+j] = sgn & raw[i*W+nbits-1];
				end
			end
		end
	end
endmodule // mas_fabric

// >>> mas_slice_bench.sv
// Self-checking bench for the multiply-accumulate slice.
`timescale 1ns/100ps
`include "mas_consts.vh"
module mas_slice_bench;
	// --------
	// Signals
	// --------
	localparam W = 18;
	localparam ACCW = 52;
	localparam [31:0] CFGS = 32'h5f5e1e1c;
	localparam [31:0] EXPS = 32'h2807170f;
	reg ref_clk = 1'b0;
	reg sys_rst = 1'b1;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	reg [3:0] tick = 4'h1;
	reg [3:0] ce = 4'h1;
	reg [3:0] rst = 4'h0;
	reg [8*W-1:0] raw = '0;
	reg [4:0] nb = 5'h12;
	reg sg = 1'b0;
	wire [8*W-1:0] ops;
	reg signedIn = 1'b0;
	reg subIn = 1'b0;
	reg accLoad = 1'b0;
	reg [ACCW-1:0] accInit = '0;
	wire [ACCW-1:0] result;
	wire overflow;
	logic [31:0] rd;
	logic busErr;
	integer err_count = 0;
	integer n_checks = 0;
	integer ovfSeen = 0;
	integer k;
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (overflow === 1'b1) begin
			ovfSeen <= ovfSeen + 1;
		end
	end
	mas_fabric #(.W(W)) fab (.raw(raw), .nbits(nb), .sgn(sg), .ops(ops));
	mas_slice #(.W(W), .ACCW(ACCW)) uut (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .slice_clock_source_0(tick[0]),
		.slice_clock_source_1(tick[1]), .slice_clock_source_2(tick[2]),
		.slice_clock_source_3(tick[3]), .slice_enable_source_0(ce[0]),
		.slice_enable_source_1(ce[1]), .slice_enable_source_2(ce[2]),
		.slice_enable_source_3(ce[3]), .slice_reset_source_0(rst[0]),
		.slice_reset_source_1(rst[1]), .slice_reset_source_2(rst[2]),
		.slice_reset_source_3(rst[3]), .opA0(ops[0+:W]), .opB0(ops[W+:W]),
		.opA1(ops[2*W+:W]), .opB1(ops[3*W+:W]), .opA2(ops[4*W+:W]),
		.opB2(ops[5*W+:W]), .opA3(ops[6*W+:W]), .opB3(ops[7*W+:W]),
		.signedIn(signedIn), .subIn(subIn), .accLoad(accLoad),
		.accInit(accInit), .result(result), .overflow(overflow));
	// --------
	// Tasks
	// --------
	task chk(input string name, input logic [63:0] got, input logic [63:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		busErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task step;
		@(posedge ref_clk);
		ce <= 4'h1;
		@(posedge ref_clk);
		ce <= 4'h0;
		repeat (4) @(posedge ref_clk);
	endtask
	task complete_run;
		$display("checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// --------
	// Tests
	// --------
	initial begin
		repeat (3000) @(posedge ref_clk);
		err_count = err_count + 1;
		complete_run;
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		apb(1'b0, `MAS_REG_CFG, 32'h0);
		chk("cfg", rd, `MAS_CFG_RESET);
		apb(1'b1, `MAS_REG_SEL, 32'hffffffff);
		apb(1'b0, `MAS_REG_SEL, 32'h0);
		chk("sel", rd, 32'h003f3f3f);
		apb(1'b1, `MAS_REG_SEL, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped", {busErr, rd}, 33'h100000000);
		$display("test registers done");
		raw <= {18'h9, 18'h1, 18'h6, 18'h7, 18'h4, 18'h2, 18'h5, 18'h3};
		for (k = 0; k < 4; k = k + 1) begin
			apb(1'b1, `MAS_REG_CFG, {24'h0, CFGS[8*k+:8]});
			repeat (6) @(posedge ref_clk);
			chk("product", result, EXPS[8*k+:8]);
		end
		apb(1'b0, `MAS_REG_RESLO, 32'h0);
		chk("low word", rd, 32'h28);
		$display("test products done");
		apb(1'b1, `MAS_REG_SEL, 32'h00360000);
		tick <= 4'hb;
		ce <= 4'hf;
		rst <= 4'h7;
		apb(1'b1, `MAS_REG_CFG, 32'h13);
		repeat (4) @(posedge ref_clk);
		chk("clock held", result, 52'h28);
		tick <= 4'h4;
		ce <= 4'hd;
		repeat (4) @(posedge ref_clk);
		chk("enable held", result, 52'h28);
		ce <= 4'h2;
		repeat (4) @(posedge ref_clk);
		chk("stage sum", result, 52'h4a);
		rst <= 4'h8;
		repeat (4) @(posedge ref_clk);
		chk("stage clear", result, 52'h0);
		rst <= 4'h0;
		tick <= 4'h1;
		ce <= 4'h0;
		apb(1'b1, `MAS_REG_SEL, 32'h0);
		$display("test stages done");
		apb(1'b1, `MAS_REG_CFG, 32'h01);
		raw <= {{6{18'h0}}, 18'h5, 18'h4};
		accLoad <= 1'b1;
		accInit <= 52'hffffffffffff0;
		step;
		chk("load", result, 52'hffffffffffff0);
		accLoad <= 1'b0;
		step;
		chk("unsigned wrap", result, 52'h4);
		apb(1'b0, `MAS_REG_STAT, 32'h0);
		chk("overflow count", rd, 32'h1);
		chk("overflow pin", ovfSeen, 1);
		apb(1'b1, `MAS_REG_STAT, 32'h0);
		apb(1'b1, `MAS_REG_CFG, 32'h81);
		signedIn <= 1'b1;
		sg <= 1'b1;
		accLoad <= 1'b1;
		accInit <= 52'h7fffffffffff0;
		step;
		accLoad <= 1'b0;
		step;
		chk("signed wrap", result, 52'h8000000000004);
		raw <= {{6{18'h0}}, 18'h5, 18'ha};
		nb <= 5'h4;
		subIn <= 1'b1;
		step;
		chk("signed sub", result, 52'h8000000000022);
		apb(1'b0, `MAS_REG_STAT, 32'h0);
		chk("overflow count", rd, 32'h1);
		chk("overflow pin", ovfSeen, 2);
		$display("test accumulate done");
		complete_run;
	end
endmodule // mas_slice_bench
